// *** core/cpu_power_mode_control.sv ***
// Power mode controller: Idle and Stop entry and exit, baud doubler, flags.
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
// Summary of operation
// - Setting the idle bit halts the CPU once the writing instruction ends.
// - In Idle only the CPU clock stops; peripheral clocks and state remain.
// - An enabled interrupt in Idle clears idle and lets the CPU resume.
// - A reset that ends Idle restarts the CPU at address 0x0000.
// - An enabled watchdog keeps running in Idle and its reset ends Idle.
// - Setting the stop bit stops CPU, oscillators and digital peripherals.
// - Only a reset ends Stop, and execution restarts at address 0x0000.
// - In Stop only, an enabled lost clock detector resets the chip after its 100 us wait.
// - The stop and idle bits always read back as zero.
// - Bit 7 doubles the serial port baud rate when set.
// - Bits 6 to 2 are general flags with no hardware effect.
module cpu_power_mode_control #(
  parameter int num_irq = 16,
  parameter int lost_clk_timeout = pwr_mode_pkg::lost_clk_cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic insn_done,
  input wire logic [num_irq-1:0] irq_flag,
  input wire logic [num_irq-1:0] irq_enable,
  input wire logic watchdog_reset,
  input wire logic lost_clock_enable,
  input wire logic osc_activity,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic lost_clock_reset,
  output logic [15:0] restart_addr,
  output logic baud_doubler,
  output logic [4:0] general_flags,
  output logic idle_active,
  output logic stop_active
);
  pwr_mode_pkg::pwr_state_t state_ff;
  pwr_mode_pkg::pwr_state_t nxt_state;
  logic baud_ff;
  logic [4:0] flags_ff;
  logic idle_req_ff;
  logic stop_req_ff;
  logic wr_hit;
  logic addr_hit;
  logic [num_irq-1:0] irq_pending;
  logic wake_irq;
  logic lost_expired;

  // Full word decode; a one-cycle access phase, never waits.
  assign addr_hit = (paddr == pwr_mode_pkg::power_control_addr);
  assign wr_hit = psel && penable && pwrite && addr_hit && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // One pending term per source; priority and the global enable play no
  // part, so any enabled source with its flag up wakes the CPU.
  for (genvar g = 0; g < num_irq; g++) begin : g_pending
    assign irq_pending[g] = irq_flag[g] & irq_enable[g];
  end
  assign wake_irq = |irq_pending;

  // Software fields of the register; they only steer outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_ff <= pwr_mode_pkg::power_control_rst[pwr_mode_pkg::baud_bit];
      flags_ff <= pwr_mode_pkg::power_control_rst[6:2];
    end else if (wr_hit) begin
      baud_ff <= pwdata[pwr_mode_pkg::baud_bit];
      flags_ff <=
        pwdata[pwr_mode_pkg::flags_hi:pwr_mode_pkg::flags_lo];
    end
  end

  // Mode requests are held until the writing instruction completes, so the
  // CPU never stops in the middle of the store that asked for it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
    end else if (wr_hit) begin
      idle_req_ff <= pwdata[pwr_mode_pkg::idle_bit];
      stop_req_ff <= pwdata[pwr_mode_pkg::stop_bit];
    end else if (insn_done) begin
      idle_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
    end
  end

  // Mode sequencer; Stop outranks Idle when both bits are written together.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pwr_mode_pkg::st_run: begin
        if (insn_done && stop_req_ff) begin
          nxt_state = pwr_mode_pkg::st_stop;
        end else if (insn_done && idle_req_ff) begin
          nxt_state = pwr_mode_pkg::st_idle;
        end
      end
      pwr_mode_pkg::st_idle: begin
        if (wake_irq) begin
          nxt_state = pwr_mode_pkg::st_run;
        end
      end
      pwr_mode_pkg::st_stop: begin
        nxt_state = pwr_mode_pkg::st_stop;
      end
      default: nxt_state = pwr_mode_pkg::st_run;
    endcase
    // A watchdog reset request ends either low-power mode at once.
    if (watchdog_reset) begin
      nxt_state = pwr_mode_pkg::st_run;
    end
  end

  // The lost clock reset leaves Stop through the chip reset, which comes
  // back here on presetn; folding the watchdog into the next state keeps
  // the clock enables in step with the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= pwr_mode_pkg::st_run;
    end else begin
      state_ff <= nxt_state;
    end
  end

  lost_clock_timer #(
    .timeout_cycles(lost_clk_timeout)
  ) u_lost_clock_timer (
    .pclk(pclk),
    .presetn(presetn),
    .enable(lost_clock_enable && (state_ff == pwr_mode_pkg::st_stop)),
    .clock_seen(osc_activity),
    .expired(lost_expired)
  );

  // Registered reset request so the chip reset sees a clean pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_clock_reset <= 1'b0;
    end else begin
      lost_clock_reset <= lost_expired;
    end
  end

  // Clock gating: Idle only drops the CPU clock, Stop drops everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
    end else begin
      cpu_clk_en <= (nxt_state == pwr_mode_pkg::st_run);
      periph_clk_en <= (nxt_state != pwr_mode_pkg::st_stop);
      osc_en <= (nxt_state != pwr_mode_pkg::st_stop);
    end
  end

  // Read data; the mode bits always read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && addr_hit) begin
      prdata <= {24'h000000, baud_ff, flags_ff, 2'b00};
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
    end
  end

  // Status outputs straight from the state, the register fields and the reset vector.
  assign restart_addr = pwr_mode_pkg::reset_vector;
  assign baud_doubler = baud_ff;
  assign general_flags = flags_ff;
  assign idle_active = (state_ff == pwr_mode_pkg::st_idle);
  assign stop_active = (state_ff == pwr_mode_pkg::st_stop);

  // Idle follows the end of the instruction that asked for it.
  property p_idle_entry;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == pwr_mode_pkg::st_run && insn_done && idle_req_ff
       && !stop_req_ff && !watchdog_reset) |=> idle_active;
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("no idle entry");

  // While idle only the CPU clock is held; the rest keeps running.
  property p_idle_clocks;
    @(posedge pclk) disable iff (!presetn)
      idle_active && $past(idle_active) |->
        !cpu_clk_en && periph_clk_en && osc_en;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks)
    else $error("idle gating");

  // An enabled pending source brings the CPU back on the next cycle.
  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      idle_active && wake_irq |=> !idle_active ##0 cpu_clk_en;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on irq");

  // Masked or absent sources leave the CPU asleep.
  property p_idle_hold;
    @(posedge pclk) disable iff (!presetn)
      idle_active && !wake_irq && !watchdog_reset |=> idle_active;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("idle left without wake");

  // Whenever no low-power mode is active, every clock runs.
  property p_run_clocks;
    @(posedge pclk) disable iff (!presetn)
      !idle_active && !stop_active |->
        cpu_clk_en && periph_clk_en && osc_en;
  endproperty
  a_run_clocks: assert property (p_run_clocks)
    else $error("clock held while running");

  // The watchdog request ends either mode.
  property p_wdt;
    @(posedge pclk) disable iff (!presetn)
      watchdog_reset |=> !idle_active && !stop_active;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog ignored");

  // A request is used once: the end of the instruction consumes it.
  property p_req_clear;
    @(posedge pclk) disable iff (!presetn)
      insn_done && !wr_hit |=> !idle_req_ff && !stop_req_ff;
  endproperty
  a_req_clear: assert property (p_req_clear)
    else $error("mode request left over");

  // Stop follows the end of the instruction that asked for it.
  property p_stop_entry;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == pwr_mode_pkg::st_run && insn_done && stop_req_ff
       && !watchdog_reset) |=> stop_active && !osc_en && !cpu_clk_en;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("no stop");

  // In Stop every clock is held, peripherals included.
  property p_stop_clocks;
    @(posedge pclk) disable iff (!presetn)
      stop_active |-> !cpu_clk_en && !periph_clk_en && !osc_en;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks)
    else $error("clock running in stop");

  // Interrupts cannot end Stop; only a reset can.
  property p_stop_hold;
    @(posedge pclk) disable iff (!presetn)
      stop_active && !watchdog_reset |=> stop_active;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop left");

  // The detector only runs out while the chip is stopped.
  property p_lost_only_stop;
    @(posedge pclk) disable iff (!presetn)
      !stop_active |-> !lost_expired;
  endproperty
  a_lost_only_stop: assert property (p_lost_only_stop)
    else $error("lost clock timeout outside stop");

  // An expired detector raises the reset request one cycle later.
  property p_lost;
    @(posedge pclk) disable iff (!presetn)
      lost_expired |=> lost_clock_reset;
  endproperty
  a_lost: assert property (p_lost)
    else $error("no lost clock reset");

  // Reads show the stored fields, never the mode bits.
  property p_read_zero;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite |-> prdata[1:0] == 2'b00 && (!addr_hit
        || prdata == {24'h000000, baud_doubler, general_flags, 2'b00});
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("mode bits read");

  // The baud doubler takes the written bit.
  property p_baud;
    @(posedge pclk) disable iff (!presetn)
      wr_hit |=> baud_doubler == $past(pwdata[7]);
  endproperty
  a_baud: assert property (p_baud)
    else $error("baud bit wrong");

  // The general flags take the written bits.
  property p_flags;
    @(posedge pclk) disable iff (!presetn)
      wr_hit |=> general_flags == $past(pwdata[6:2]);
  endproperty
  a_flags: assert property (p_flags)
    else $error("flags wrong");

  // Main scenarios: wake, Stop, lost clock, watchdog in Idle, both bits.
  c_idle_wake: cover property (@(posedge pclk) idle_active ##1 !idle_active);
  c_stop: cover property (@(posedge pclk) stop_active);
  c_lost: cover property (@(posedge pclk) lost_clock_reset);
  c_wdt_idle: cover property (@(posedge pclk) watchdog_reset && idle_active);
  c_both_req: cover property (@(posedge pclk)
    insn_done && idle_req_ff && stop_req_ff);
endmodule : cpu_power_mode_control

// *** core/pwr_mode_pkg.sv ***
// Package of constants for the processor power mode controller.
package pwr_mode_pkg;
  // Register byte address (0x87 is not a multiple of four: index times 4).
  localparam logic [7:0] power_control_idx = 8'h87;
  localparam logic [11:0] power_control_addr = 12'h21c;
  localparam logic [7:0] power_control_rst = 8'h00;
  // Field positions inside the power control register.
  localparam int idle_bit = 0;
  localparam int stop_bit = 1;
  localparam int flags_lo = 2;
  localparam int flags_hi = 6;
  localparam int baud_bit = 7;
  // Restart address after any reset that ends a low-power mode.
  localparam logic [15:0] reset_vector = 16'h0000;
  // Lost clock detector timeout in nanoseconds and in system clock cycles.
  localparam int lost_clk_timeout_ns = 100000;
  localparam int clk_period_ns = 20;
  localparam int lost_clk_cycles = lost_clk_timeout_ns / clk_period_ns;
  typedef enum logic [1:0] {st_run, st_idle, st_stop} pwr_state_t;
endpackage : pwr_mode_pkg

// *** core/lost_clock_timer.sv ***
// Timeout counter of the lost clock detector used to leave Stop.
`timescale 1ns/10ps
module lost_clock_timer #(
  parameter int timeout_cycles = pwr_mode_pkg::lost_clk_cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic clock_seen,
  output logic expired
);
  logic [15:0] count_ff;

  // Counts cycles with no clock activity; any activity restarts the wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 16'h0000;
    end else if (!enable || clock_seen) begin
      count_ff <= 16'h0000;
    end else if (count_ff != timeout_cycles[15:0]) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  assign expired = enable && (count_ff == timeout_cycles[15:0]);
endmodule : lost_clock_timer

// *** bench/tb.sv ***
// Self-checking testbench of the processor power mode controller.
`timescale 1ns/10ps
module tb;
  localparam int lost_t = 20;
  localparam logic [11:0] reg_a = pwr_mode_pkg::power_control_addr;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_clk_en, periph_clk_en, osc_en;
  logic insn_done = 1'b0;
  logic [15:0] irq_flag = 16'h0;
  logic [15:0] irq_enable = 16'h0;
  logic watchdog_reset = 1'b0;
  logic lost_clock_enable = 1'b0;
  logic osc_activity = 1'b1;
  logic lost_clock_reset, baud_doubler, idle_active, stop_active;
  logic [15:0] restart_addr;
  logic [4:0] general_flags;
  logic [31:0] rd, w;
  logic err;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed, i, k;

  cpu_power_mode_control #(.lost_clk_timeout(lost_t)) i_dut (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .insn_done, .irq_flag, .irq_enable, .watchdog_reset,
    .lost_clock_enable, .osc_activity, .cpu_clk_en, .periph_clk_en, .osc_en,
    .lost_clock_reset, .restart_addr, .baud_doubler, .general_flags,
    .idle_active, .stop_active);

  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;

  task automatic test_done;
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk

  // Read value of the register: mode bits never read back set.
  function automatic logic [31:0] exp_rd(input logic [31:0] v);
    return {24'h0, v[7:2], 2'b00};
  endfunction : exp_rd

  // One APB transfer; an idle cycle follows so calls never collide.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 20) begin
      error_cnt++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // One-cycle pulse marking the end of the writing instruction.
  task automatic insn;
    insn_done <= 1'b1;
    @(posedge pclk);
    insn_done <= 1'b0;
    @(posedge pclk);
  endtask : insn

  // Bounded wait for a state output: 0 idle, 1 stop, 2 lost clock reset.
  task automatic await(input int sel, input logic val);
    int n;
    for (n = 0; n < 100; n++) begin
      if ((sel == 0 ? idle_active : sel == 1 ? stop_active
           : lost_clock_reset) === val) break;
      @(posedge pclk);
    end
    if (n == 100) begin
      error_cnt++;
      test_done();
    end
  endtask : await

  // A hang anywhere is cut short here.
  initial begin
    #1000000;
    error_cnt++;
    test_done();
  end

  initial begin
    seed = 32'hfb7d52d3;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("cpu_clk_en", 1, cpu_clk_en);
    chk("pready", 1, pready);
    apb(1'b0, reg_a, 32'h0);
    chk("reset read", 32'h0, rd);
    // Random writes, stray mode bits included; the last one clears them.
    for (i = 0; i < 10; i++) begin
      w = (i == 0) ? 32'hff : $random(seed);
      if (i == 9) w[1:0] = 2'b00;
      apb(1'b1, reg_a, w);
      apb(1'b0, reg_a, 32'h0);
      chk("read", exp_rd(w), rd);
      chk("baud_doubler", w[7], baud_doubler);
      chk("general_flags", w[6:2], general_flags);
    end
    // Idle entry, then masked sources must not wake, one enabled must.
    apb(1'b1, reg_a, w | 32'h1);
    // The setting write is followed by the one-cycle end pulse of its own instruction.
    insn();
    await(0, 1'b1);
    chk("idle cpu_clk_en", 0, cpu_clk_en);
    chk("idle periph_clk_en", 1, periph_clk_en);
    chk("idle osc_en", 1, osc_en);
    k = $random(seed);
    irq_flag <= k[15:0];
    irq_enable <= ~k[15:0];
    repeat (8) @(posedge pclk);
    chk("masked idle", 1, idle_active);
    k = {$random(seed)} % 16;
    irq_flag[k] <= 1'b1;
    irq_enable <= 16'h1 << k;
    await(0, 1'b0);
    chk("wake cpu_clk_en", 1, cpu_clk_en);
    irq_flag <= 16'h0;
    apb(1'b0, reg_a, 32'h0);
    chk("idle keeps flags", exp_rd(w), rd);
    // Watchdog reset ends Idle.
    apb(1'b1, reg_a, 32'h1);
    insn();
    await(0, 1'b1);
    watchdog_reset <= 1'b1;
    @(posedge pclk);
    watchdog_reset <= 1'b0;
    await(0, 1'b0);
    chk("restart_addr", pwr_mode_pkg::reset_vector, restart_addr);
    // Stop: interrupts do not wake; lost clock detector fires.
    lost_clock_enable <= 1'b1;
    // Both mode bits at once: Stop wins. Analog parts sit outside this
    // block, so there is nothing to shut down before the write.
    apb(1'b1, reg_a, 32'h3);
    insn();
    await(1, 1'b1);
    chk("stop osc_en", 0, osc_en);
    chk("stop periph_clk_en", 0, periph_clk_en);
    chk("stop not idle", 0, idle_active);
    chk("stop cpu_clk_en", 0, cpu_clk_en);
    irq_flag <= 16'hffff;
    irq_enable <= 16'hffff;
    osc_activity <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("stop irq", 1, stop_active);
    await(2, 1'b1);
    presetn <= 1'b0;
    irq_flag <= 16'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    osc_activity <= 1'b1;
    @(posedge pclk);
    chk("stop after reset", 0, stop_active);
    chk("restart_addr", pwr_mode_pkg::reset_vector, restart_addr);
    // Long Stop with the detector switched off: no reset, however long.
    lost_clock_enable <= 1'b0;
    apb(1'b1, reg_a, 32'h2);
    insn();
    await(1, 1'b1);
    osc_activity <= 1'b0;
    repeat (3 * lost_t) @(posedge pclk);
    chk("long stop lost_clock_reset", 0, lost_clock_reset);
    chk("long stop", 1, stop_active);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    osc_activity <= 1'b1;
    @(posedge pclk);
    chk("long stop after reset", 0, stop_active);
    // Unmapped address is refused and leaves the register alone.
    apb(1'b1, reg_a + 12'h4, 32'hfc);
    chk("pslverr", 1, err);
    apb(1'b0, reg_a, 32'h0);
    chk("after refused", 32'h0, rd);
    test_done();
  end
endmodule : tb
